// [hpp_pkg.sv]
// Notes on behaviour
// - static strap selects ganged or per-port mode
// - overcurrent inputs active low, one per port
// - ganged mode combines overcurrent inputs by gating
// - one active-low open-drain enable per port
// - ganged mode switches all enables together
// - reset active high, 250 ns, full reinit
// - enables derive from gang, control register, overcurrent
// - static active-low bus-powered strap is read
package hpp_pkg;
    // port count
    localparam int NUM_PORTS = 4;
    // clock and reset timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int RESET_MIN_NS = 250;
    localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] RESET_CNT_MAX = 2'(RESET_MIN_CYCLES);
    // apb register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
    // status register field positions
    localparam int STAT_GANGED_BIT = 4;
    localparam int STAT_BUS_POWERED_N_BIT = 5;
    localparam int STAT_OSCILLATOR_DISABLE_BIT = 6;
    localparam int STAT_ENABLE_LSB = 8;
    // reset values
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage : hpp_pkg

// [hpp_reset_sync.sv]
`timescale 1ns/1ps
// stretches reset so internal logic reinitialises for the minimum time
module hpp_reset_sync
    import hpp_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    output logic coreReset
);
    // remaining cycles of held reset
    logic [1:0] holdCnt_reg;

    // reload on reset, then count down before releasing
    always_ff @(posedge clk) begin
        if (reset) begin
            holdCnt_reg <= RESET_CNT_MAX;
            coreReset <= 1'b1;
        end else if (clkEn) begin
            if (holdCnt_reg != 2'h0) begin
                holdCnt_reg <= holdCnt_reg - 2'h1;
            end
            coreReset <= (holdCnt_reg != 2'h0);
        end
    end
endmodule : hpp_reset_sync

// [hpp_port_power.sv]
`timescale 1ns/1ps
// combinational power decision for all ports
module hpp_port_power
    import hpp_pkg::*;
#(
    parameter int PORTS = NUM_PORTS
)(
    input wire logic gangedMode,
    input wire logic [PORTS-1:0] portOn,
    input wire logic [PORTS-1:0] overcurrentFlag_n,
    output logic [PORTS-1:0] powerRequest,
    output logic [PORTS-1:0] portFault
);
    // any active-low flag low means a fault
    logic anyFault;

    // faults are active low inputs; ganged mode gates them together
    always_comb begin
        anyFault = ~(&overcurrentFlag_n);
        if (gangedMode) begin
            portFault = {PORTS{anyFault}};
            powerRequest = (portOn[0] && !anyFault) ? {PORTS{1'b1}} : {PORTS{1'b0}};
        end else begin
            portFault = ~overcurrentFlag_n;
            powerRequest = portOn & overcurrentFlag_n;
        end
    end
endmodule : hpp_port_power

// [hpp_power_ctrl.sv]
`timescale 1ns/1ps
// hub downstream power control with apb registers and interrupt
module hpp_power_ctrl
    import hpp_pkg::*;
#(
    parameter int PORTS = NUM_PORTS
)(
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic gangedMode,
    input wire logic busPowered_n,
    input wire logic oscillatorDisable,
    input wire logic [PORTS-1:0] overcurrentFlag_n,
    output logic [PORTS-1:0] portPowerEnable_n,
    output logic [PORTS-1:0] portPowerEnableOe,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    // internal reset, stretched
    logic coreReset;
    // sampled straps
    logic ganged_reg;
    logic bus_powered_n_reg;
    // software port power requests
    logic [PORTS-1:0] ctrl_reg;
    // sticky overcurrent events and enables
    logic [PORTS-1:0] irqStat_reg;
    logic [PORTS-1:0] irqEn_reg;
    // previous fault level for edge detection
    logic [PORTS-1:0] faultPrev_reg;
    // combinational power decision
    logic [PORTS-1:0] powerRequest;
    logic [PORTS-1:0] portFault;
    // access phase strobes
    logic apbWrite;
    logic apbRead;
    // power requests straight from control register, not gated by bus-power strap
    logic [PORTS-1:0] portOn;

    // strobes fire in the first access-phase cycle only, before pready
    assign apbWrite = psel && penable && pwrite && !pready;
    assign apbRead = psel && penable && !pwrite && !pready;

    // bus-powered hub may still switch ports; strap only recorded
    assign portOn = ctrl_reg;

    // reset stretcher
    hpp_reset_sync u_reset (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .coreReset(coreReset)
    );

    // power decision
    hpp_port_power #(.PORTS(PORTS)) u_power (
        .gangedMode(ganged_reg),
        .portOn(portOn),
        .overcurrentFlag_n(overcurrentFlag_n),
        .powerRequest(powerRequest),
        .portFault(portFault)
    );

    // straps caught after reset release, assumed static afterward
    always_ff @(posedge clk) begin
        if (reset) begin
            ganged_reg <= 1'b0;
            bus_powered_n_reg <= 1'b0;
        end else if (clkEn && coreReset) begin
            ganged_reg <= gangedMode;
            bus_powered_n_reg <= ~busPowered_n;
        end
    end

    // control register write
    always_ff @(posedge clk) begin
        if (coreReset) begin
            ctrl_reg <= CTRL_RESET[PORTS-1:0];
        end else if (clkEn && apbWrite && paddr == ADDR_CTRL) begin
            ctrl_reg <= pwdata[PORTS-1:0];
        end
    end

    // open-drain enables: drive low only to request power
    always_ff @(posedge clk) begin
        if (coreReset) begin
            portPowerEnable_n <= {PORTS{1'b1}};
            portPowerEnableOe <= {PORTS{1'b0}};
        end else if (clkEn) begin
            portPowerEnable_n <= ~powerRequest;
            portPowerEnableOe <= powerRequest;
        end
    end

    // sticky fault status: set wins over clear
    always_ff @(posedge clk) begin
        if (coreReset) begin
            irqStat_reg <= IRQ_RESET[PORTS-1:0];
            faultPrev_reg <= {PORTS{1'b0}};
        end else if (clkEn) begin
            faultPrev_reg <= portFault;
            if (apbWrite && paddr == ADDR_IRQ_CLR) begin
                irqStat_reg <= (irqStat_reg & ~pwdata[PORTS-1:0]) | (portFault & ~faultPrev_reg);
            end else begin
                irqStat_reg <= irqStat_reg | (portFault & ~faultPrev_reg);
            end
        end
    end

    // interrupt enable register
    always_ff @(posedge clk) begin
        if (coreReset) begin
            irqEn_reg <= IRQ_RESET[PORTS-1:0];
        end else if (clkEn && apbWrite && paddr == ADDR_IRQ_EN) begin
            irqEn_reg <= pwdata[PORTS-1:0];
        end
    end

    // interrupt level output
    always_ff @(posedge clk) begin
        if (coreReset) begin
            irq <= 1'b0;
        end else if (clkEn) begin
            irq <= |(irqStat_reg & irqEn_reg);
        end
    end

    // apb answer: one wait state, read data registered
    always_ff @(posedge clk) begin
        if (coreReset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= READ_ZERO;
        end else if (clkEn) begin
            pready <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata <= READ_ZERO;
            if (psel && penable && !pready) begin
                // unmapped offsets answer with an error
                unique case (paddr)
                    ADDR_CTRL: begin
                        prdata[PORTS-1:0] <= ctrl_reg;
                    end
                    ADDR_STATUS: begin
                        prdata[PORTS-1:0] <= portFault;
                        prdata[STAT_GANGED_BIT] <= ganged_reg;
                        prdata[STAT_BUS_POWERED_N_BIT] <= bus_powered_n_reg;
                        prdata[STAT_OSCILLATOR_DISABLE_BIT] <= oscillatorDisable;
                        prdata[STAT_ENABLE_LSB +: PORTS] <= ~portPowerEnable_n;
                    end
                    ADDR_IRQ_STAT: begin
                        prdata[PORTS-1:0] <= irqStat_reg;
                    end
                    ADDR_IRQ_CLR: begin
                        prdata <= READ_ZERO;
                    end
                    ADDR_IRQ_EN: begin
                        prdata[PORTS-1:0] <= irqEn_reg;
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule : hpp_power_ctrl

// [hpp_power_ctrl_asserts.sv]
`timescale 1ns/1ps
// port checks for the power controller
module hpp_power_ctrl_asserts
    import hpp_pkg::*;
#(parameter int PORTS = NUM_PORTS) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic gangedMode,
    input wire logic [PORTS-1:0] overcurrentFlag_n,
    input wire logic [PORTS-1:0] portPowerEnable_n,
    input wire logic [PORTS-1:0] portPowerEnableOe,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // an access phase not yet answered
    sequence s_req; psel && penable && !pready && clkEn; endsequence
    property p_ans; s_req |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("access not answered");
    property p_pulse; pready && clkEn |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready held");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without pready");
    property p_oe; portPowerEnableOe == ~portPowerEnable_n; endproperty
    a_oe: assert property (p_oe) else $error("enable drive mismatch");
    property p_gang; gangedMode |-> (&portPowerEnable_n || !(|portPowerEnable_n)); endproperty
    a_gang: assert property (p_gang) else $error("ganged enables split");
    property p_gdrop; gangedMode && !(&overcurrentFlag_n) && clkEn |=> &portPowerEnable_n; endproperty
    a_gdrop: assert property (p_gdrop) else $error("ganged fault kept power");
    property p_pdrop; !gangedMode && clkEn |=> &(portPowerEnable_n | $past(overcurrentFlag_n)); endproperty
    a_pdrop: assert property (p_pdrop) else $error("faulted port kept power");
    // internal reset lands one edge after the pin, so look after two reset cycles
    property p_rst; disable iff (1'b0) reset ##1 reset |=> &portPowerEnable_n && !irq && !pready; endproperty
    a_rst: assert property (p_rst) else $error("outputs not reset");
endmodule : hpp_power_ctrl_asserts

bind hpp_power_ctrl hpp_power_ctrl_asserts #(.PORTS(PORTS)) chk_u (.clk(clk), .reset(reset), .clkEn(clkEn),
    .gangedMode(gangedMode), .overcurrentFlag_n(overcurrentFlag_n), .portPowerEnable_n(portPowerEnable_n),
    .portPowerEnableOe(portPowerEnableOe), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .irq(irq));

// [hpp_switch_model.sv]
`timescale 1ns/1ps
// external power switches with pull-ups and fault detectors
module hpp_switch_model (
    input wire logic [3:0] portPowerEnable_n,
    input wire logic [3:0] portPowerEnableOe,
    input wire logic [3:0] faultInject,
    output logic [3:0] overcurrentFlag_n,
    output logic [3:0] portPowered
);
    // pull-up lifts a released pin
    assign portPowered = portPowerEnableOe & ~portPowerEnable_n;
    // detector idles high, pulls low on fault
    assign overcurrentFlag_n = ~faultInject;
endmodule : hpp_switch_model

// [tb.sv]
`timescale 1ns/1ps
// self-checking bench for the hub power controller
module tb;
    import hpp_pkg::*;
    logic clk = 0, reset = 1, clkEn = 1, gangedMode = 0, busPowered_n = 1;
    logic oscillatorDisable = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0] faultInject = 0, portPowerEnable_n, portPowerEnableOe, overcurrentFlag_n, portPowered;
    logic [3:0] ctrl, stat, en, flt; // model state
    logic [7:0] regs [4] = '{ADDR_CTRL, ADDR_IRQ_STAT, ADDR_IRQ_CLR, ADDR_IRQ_EN};
    int errCount = 0, totalChecks = 0, cycles = 0;
    hpp_power_ctrl dut_u (.clk(clk), .reset(reset), .clkEn(clkEn), .gangedMode(gangedMode),
        .busPowered_n(busPowered_n), .oscillatorDisable(oscillatorDisable), .overcurrentFlag_n(overcurrentFlag_n),
        .portPowerEnable_n(portPowerEnable_n), .portPowerEnableOe(portPowerEnableOe), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    hpp_switch_model sw_u (.portPowerEnable_n(portPowerEnable_n), .portPowerEnableOe(portPowerEnableOe),
        .faultInject(faultInject), .overcurrentFlag_n(overcurrentFlag_n), .portPowered(portPowered));
    initial forever #50 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errCount++;
            closeOut();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task closeOut();
        $display("checks %0d errors %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : closeOut
    // one apb transfer, waits for pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask : apb
    // expected powered ports
    function logic [3:0] expOn();
        if (gangedMode) return (ctrl[0] && flt == 0) ? 4'hF : 4'h0;
        return ctrl & ~flt;
    endfunction : expOn
    // strap only changes under reset
    task doReset(input logic g);
        reset <= 1;
        gangedMode <= g;
        busPowered_n <= 1'($urandom);
        faultInject <= 0;
        repeat (3) @(posedge clk);
        chk(portPowerEnable_n, 4'hF);
        reset <= 0;
        repeat (3) @(posedge clk);
        {ctrl, stat, en, flt} = 0;
    endtask : doReset
    task step(input logic [3:0] c, input logic [3:0] f, input logic [3:0] e, input logic [3:0] k);
        apb(1, ADDR_IRQ_EN, {28'h0, e});
        en = e;
        apb(1, ADDR_CTRL, {28'h0, c});
        ctrl = c;
        faultInject <= f;
        stat |= f & ~flt;
        flt = f;
        repeat (3) @(posedge clk);
        chk(portPowered, expOn());
        if (!gangedMode) begin
            chk(irq, |(stat & en));
            apb(0, ADDR_STATUS, 0);
            chk(rd & 32'h0F7F, {20'h0, expOn(), 2'h0, ~busPowered_n, 1'h0, flt});
            apb(0, ADDR_IRQ_STAT, 0);
            chk(rd, {28'h0, stat});
            apb(1, ADDR_IRQ_CLR, {28'h0, k});
            stat &= ~k;
            chk(irq, |(stat & en));
        end
    endtask : step
    initial begin
        rd = $urandom(32'h6872);
        doReset(0);
        foreach (regs[i]) begin
            apb(0, regs[i], 0);
            chk(rd, READ_ZERO);
        end
        apb(0, 8'h14, 0);
        chk(err, 1'b1);
        for (int i = 0; i < 16; i++) begin
            step(i[0] ? 4'hF : 4'($urandom), i[0] ? 4'($urandom) : 4'h0, 4'($urandom), 4'($urandom));
        end
        // clock enable low: enables must hold although the flags move
        clkEn <= 0;
        faultInject <= ~flt;
        repeat (3) @(posedge clk);
        chk(portPowered, expOn());
        faultInject <= flt;
        clkEn <= 1;
        repeat (2) @(posedge clk);
        doReset(1);
        for (int i = 0; i < 10; i++) begin
            step(4'($urandom), {4{1'($urandom)}}, 4'h0, 4'h0);
        end
        closeOut();
    end
endmodule : tb
